// ---- design/rsdp_pkg.sv ----
package rsdp_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;

  // ****************************************
  // Field codes
  // ****************************************
  // Packet format field values
  localparam logic [1:0] FMT_NORMAL = 2'h0;
  localparam logic [1:0] FMT_SYNC = 2'h1;
  localparam logic [1:0] FMT_ASYNC = 2'h3;
  // Pin function select values
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_CLK = 2'h2;
  localparam logic [1:0] SEL_HIZ = 2'h3;
  // Command and status bit positions
  localparam int CMD_TX_BIT = 0;
  localparam int CMD_IDLE_BIT = 1;
  localparam int STAT_OVR_BIT = 5;

  // ****************************************
  // Timing and reset values
  // ****************************************
  localparam int OSR = 8;
  localparam int TX_LAT = 8;
  localparam int RX_LAT = 9;
  localparam logic [2:0] PHASE_MID = 3'h3;
  localparam logic [2:0] PHASE_END = 3'h7;
  localparam logic [15:0] RATE_RST = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] pin2_sel;
    logic [1:0] pin1_sel;
    logic [1:0] pin0_sel;
    logic [2:0] sync_qual;
    logic [1:0] length_mode;
    logic checksum_en;
    logic [1:0] fmt;
  } rsdp_ctrl_t;

  typedef struct packed {
    logic sync_bit;
    logic data;
  } rsdp_txw_t;

  localparam rsdp_ctrl_t CTRL_RST = 14'h0000;
  localparam rsdp_txw_t TXW_RST = 2'h0;

endpackage

// ---- design/rsdp_sync2.sv ----
`timescale 1ns/1ps
module rsdp_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);

  logic meta_q;

  // Two stage synchroniser, first stage read only here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ---- design/rsdp_buf2.sv ----
`timescale 1ns/1ps
module rsdp_buf2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input rsdp_pkg::rsdp_txw_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output rsdp_pkg::rsdp_txw_t out_data
);

  logic v1_q;
  rsdp_pkg::rsdp_txw_t d1_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Full only when the second entry holds a word
  assign in_ready = !v1_q;

  // Head entry drives the output directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= rsdp_pkg::TXW_RST;
      v1_q <= 1'b0;
      d1_q <= rsdp_pkg::TXW_RST;
    end else if (pop) begin
      out_data <= v1_q ? d1_q : in_data;
      out_valid <= v1_q | push;
      v1_q <= v1_q & push;
      d1_q <= in_data;
    end else if (!out_valid) begin
      out_valid <= push;
      out_data <= in_data;
    end else if (push) begin
      v1_q <= 1'b1;
      d1_q <= in_data;
    end
  end

endmodule

// ---- design/rsdp_top.sv ----
// How it works
// [RULE_01] Packet format field at 3 selects asynchronous serial mode.
// [RULE_02] Asynchronous mode bypasses packet handling and forbids Manchester coding.
// [RULE_03] Transmit strobe in asynchronous mode makes pin 0 an input, ignoring its select.
// [RULE_04] Receive data goes out on any pin whose select chooses data output.
// [RULE_05] Asynchronous transmit input is sampled at eight times the data rate.
// [RULE_06] Host keeps its bit period error below one eighth of a bit.
// [RULE_07] Asynchronous receive output is the raw level, no bit decision.
// [RULE_08] Host oversamples receive output and tolerates one eighth bit jitter.
// [RULE_09] Host filters rare one crystal period glitches on asynchronous output.
// [RULE_10] Packet format field at 1 selects synchronous serial mode.
// [RULE_11] Host sets sync qualifier to 000 and clears checksum enable.
// [RULE_12] Host selects infinite length with length mode 10b.
// [RULE_13] Device generates the bit clock in synchronous mode.
// [RULE_14] Synchronous transmit data enters on pin 0, switched to input while sending.
// [RULE_15] Synchronous transmit latency is eight bit periods.
// [RULE_16] Synchronous receive latency is nine bit periods.
// [RULE_17] Host handles preamble, sync word and checksum itself.
// [RULE_18] Bit clock toggles once per bit; data changes and samples on opposite edges. Code toggles it twice per bit, rising mid-bit, falling at bit end.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module rsdp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic general_output_pin_0_in,
  output logic general_output_pin_0_out,
  output logic general_output_pin_0_oe,
  output logic general_output_pin_1_out,
  output logic general_output_pin_1_oe,
  output logic general_output_pin_2_out,
  output logic general_output_pin_2_oe,
  input wire logic rx_raw_level,
  input wire logic rx_bit,
  output logic tx_mod_valid,
  input wire logic tx_mod_ready,
  output rsdp_pkg::rsdp_txw_t tx_mod_data,
  output logic pkt_bypass,
  output logic manchester_en,
  output logic tx_active
);

  // ****************************************
  // Declarations
  // ****************************************
  rsdp_pkg::rsdp_ctrl_t ctrl_q;
  logic [15:0] rate_q;
  logic tx_active_q;
  logic ovr_q;
  logic async_q;
  logic sync_q;
  logic pkt_bypass_q;
  logic manchester_en_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [15:0] os_cnt_q;
  logic [2:0] phase_q;
  logic bclk_q;
  logic [rsdp_pkg::TX_LAT-1:0] tx_line_q;
  logic [rsdp_pkg::RX_LAT-1:0] rx_line_q;
  logic rx_dat_q;
  logic [2:0] gp_out_q;
  logic [2:0] gp_oe_q;
  logic [2:0] gp_out_d;
  logic [2:0] gp_oe_d;
  logic pin0_s;
  logic buf_in_ready;
  rsdp_pkg::rsdp_txw_t push_data;

  // ****************************************
  // APB decode
  // ****************************************
  // Access phase, write strobe and address hits
  wire acc = psel & penable;
  wire acc_first = acc & !pready_q;
  wire wr_en = acc & pwrite & pready_q;
  wire hit_ctrl = (paddr == rsdp_pkg::ADDR_CTRL);
  wire hit_rate = (paddr == rsdp_pkg::ADDR_RATE);
  wire hit_cmd = (paddr == rsdp_pkg::ADDR_CMD);
  wire hit_stat = (paddr == rsdp_pkg::ADDR_STAT);
  wire mapped = hit_ctrl | hit_rate | hit_cmd | hit_stat;
  wire wr_ctrl = wr_en & hit_ctrl;
  wire wr_rate = wr_en & hit_rate;
  wire wr_cmd = wr_en & hit_cmd;
  wire wr_stat = wr_en & hit_stat;
  wire [31:0] stat_w = {26'h0, ovr_q, !buf_in_ready, pkt_bypass_q, sync_q,
                        async_q, tx_active_q};
  wire [31:0] rd_data = hit_ctrl ? {18'h0, ctrl_q} :
                        hit_rate ? {16'h0, rate_q} :
                        hit_stat ? stat_w : 32'h0;

  // Bus answer after one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & !mapped;
      prdata_q <= (acc_first & !pwrite) ? rd_data : 32'h0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Configuration and rate registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= rsdp_pkg::CTRL_RST;
      rate_q <= rsdp_pkg::RATE_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= pwdata[13:0];
      if (wr_rate) rate_q <= pwdata[15:0];
    end
  end

  // Transmit strobe wins over idle strobe
  wire tx_set = wr_cmd & pwdata[rsdp_pkg::CMD_TX_BIT];
  wire tx_clr = wr_cmd & pwdata[rsdp_pkg::CMD_IDLE_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_active_q <= 1'b0;
    else if (tx_set) tx_active_q <= 1'b1;
    else if (tx_clr) tx_active_q <= 1'b0;
  end

  // Mode flags decoded from the packet format field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      async_q <= 1'b0;
      sync_q <= 1'b0;
      pkt_bypass_q <= 1'b0;
      manchester_en_q <= 1'b1;
    end else begin
      async_q <= (ctrl_q.fmt == rsdp_pkg::FMT_ASYNC); // [RULE_01]
      sync_q <= (ctrl_q.fmt == rsdp_pkg::FMT_SYNC); // [RULE_10]
      pkt_bypass_q <= async_q | sync_q; // [RULE_02]
      manchester_en_q <= !async_q; // [RULE_02]
    end
  end

  // ****************************************
  // Rate divider and bit clock
  // ****************************************
  // One oversample tick per eighth of a bit; lowering the rate cannot stall it
  wire os_tick = (os_cnt_q >= rate_q);
  wire mid_tick = os_tick & (phase_q == rsdp_pkg::PHASE_MID);
  wire bit_tick = os_tick & (phase_q == rsdp_pkg::PHASE_END);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_cnt_q <= 16'h0000;
      phase_q <= 3'h0;
    end else if (os_tick) begin
      os_cnt_q <= 16'h0000;
      phase_q <= phase_q + 3'h1; // [RULE_05]
    end else begin
      os_cnt_q <= os_cnt_q + 16'h0001;
    end
  end

  // Clock rises mid-bit, falls at bit boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bclk_q <= 1'b0;
    else if (mid_tick) bclk_q <= 1'b1; // [RULE_13] [RULE_18]
    else if (bit_tick) bclk_q <= 1'b0; // [RULE_18]
  end

  // ****************************************
  // Transmit path
  // ****************************************
  rsdp_sync2 u_pin0_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(general_output_pin_0_in),
    .q(pin0_s)
  );

  // Eight bit delay, shifted on the rising bit clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_line_q <= '0;
    else if (sync_q & mid_tick) tx_line_q <= {tx_line_q[6:0], pin0_s}; // [RULE_15]
  end

  // Samples per tick in async, delayed bits per bit in sync
  wire push_async = async_q & os_tick; // [RULE_05]
  wire push_sync = sync_q & mid_tick; // [RULE_14]
  wire push_valid = tx_active_q & (push_async | push_sync);
  assign push_data.sync_bit = sync_q;
  assign push_data.data = async_q ? pin0_s : tx_line_q[rsdp_pkg::TX_LAT-1]; // [RULE_15]

  rsdp_buf2 u_txbuf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_valid),
    .in_ready(buf_in_ready),
    .in_data(push_data),
    .out_valid(tx_mod_valid),
    .out_ready(tx_mod_ready),
    .out_data(tx_mod_data)
  );

  // Sticky overrun when the buffer refuses; set beats clear
  wire ovr_set = push_valid & !buf_in_ready;
  wire ovr_clr = wr_stat & pwdata[rsdp_pkg::STAT_OVR_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovr_q <= 1'b0;
    else if (ovr_set) ovr_q <= 1'b1;
    else if (ovr_clr) ovr_q <= 1'b0;
  end

  // ****************************************
  // Receive path
  // ****************************************
  // Nine stage delay, pin updated on falling bit clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_line_q <= '0;
      rx_dat_q <= 1'b0;
    end else if (sync_q & bit_tick) begin
      rx_line_q <= {rx_line_q[7:0], rx_bit}; // [RULE_16]
      rx_dat_q <= rx_line_q[rsdp_pkg::RX_LAT-1]; // [RULE_16]
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Raw level in async mode, delayed bit in sync mode
  wire data_val = async_q ? rx_raw_level : rx_dat_q; // [RULE_07]
  wire pin0_input = tx_active_q & (async_q | sync_q); // [RULE_03] [RULE_14]
  wire [2:0][1:0] sel_w = {ctrl_q.pin2_sel, ctrl_q.pin1_sel, ctrl_q.pin0_sel};

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pin
      wire is_data = (sel_w[p] == rsdp_pkg::SEL_DATA);
      wire is_clk = (sel_w[p] == rsdp_pkg::SEL_CLK);
      wire turned = (p == 0) & pin0_input;
      assign gp_out_d[p] = is_data ? data_val : (is_clk & sync_q & bclk_q); // [RULE_04]
      assign gp_oe_d[p] = (sel_w[p] != rsdp_pkg::SEL_HIZ) & !turned; // [RULE_03]
    end
  endgenerate

  // Pin registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_out_q <= 3'h0;
      gp_oe_q <= 3'h0;
    end else begin
      gp_out_q <= gp_out_d;
      gp_oe_q <= gp_oe_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign general_output_pin_0_out = gp_out_q[0];
  assign general_output_pin_0_oe = gp_oe_q[0];
  assign general_output_pin_1_out = gp_out_q[1];
  assign general_output_pin_1_oe = gp_oe_q[1];
  assign general_output_pin_2_out = gp_out_q[2];
  assign general_output_pin_2_oe = gp_oe_q[2];
  assign pkt_bypass = pkt_bypass_q;
  assign manchester_en = manchester_en_q;
  assign tx_active = tx_active_q;

  // ****************************************
  // Assertions
  // ****************************************
  // Gap counter between oversample ticks
  logic [16:0] gap_q;
  logic seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 17'h00000;
      seen_q <= 1'b0;
    end else if (os_tick) begin
      gap_q <= 17'h00000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 17'h00001;
    end
  end

  property p_fmt_async;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl && pwdata[1:0] == rsdp_pkg::FMT_ASYNC |=> ##1 async_q ##1 (pkt_bypass_q && !manchester_en_q);
  endproperty
  a_fmt_async: assert property (p_fmt_async) else $error("async mode not entered"); // [RULE_01]

  property p_no_manchester;
    @(posedge pclk) disable iff (!presetn)
    async_q [*2] |-> !manchester_en_q && pkt_bypass_q;
  endproperty
  a_no_manchester: assert property (p_no_manchester) else $error("coding on in async"); // [RULE_02]

  property p_fmt_sync;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl && pwdata[1:0] == rsdp_pkg::FMT_SYNC |=> ##1 (sync_q && !async_q);
  endproperty
  a_fmt_sync: assert property (p_fmt_sync) else $error("sync mode not entered"); // [RULE_10]

  property p_pin0_in;
    @(posedge pclk) disable iff (!presetn)
    tx_active_q && (async_q || sync_q) |=> !general_output_pin_0_oe;
  endproperty
  a_pin0_in: assert property (p_pin0_in) else $error("pin 0 driven in transmit"); // [RULE_03]

  property p_raw_out;
    @(posedge pclk) disable iff (!presetn)
    async_q && ctrl_q.pin1_sel == rsdp_pkg::SEL_DATA |=>
      general_output_pin_1_out == $past(rx_raw_level) && general_output_pin_1_oe;
  endproperty
  a_raw_out: assert property (p_raw_out) else $error("raw level not on data pin"); // [RULE_07]

  property p_os_rate;
    @(posedge pclk) disable iff (!presetn)
    os_tick && seen_q && !$past(wr_rate) |-> gap_q == {1'b0, rate_q};
  endproperty
  a_os_rate: assert property (p_os_rate) else $error("oversample spacing wrong"); // [RULE_05]

  property p_async_sample;
    @(posedge pclk) disable iff (!presetn)
    tx_active_q && async_q && os_tick |-> push_valid && push_data.data == pin0_s;
  endproperty
  a_async_sample: assert property (p_async_sample) else $error("tick sample missed"); // [RULE_05]

  property p_bclk;
    @(posedge pclk) disable iff (!presetn)
    mid_tick |=> bclk_q until bit_tick;
  endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock high phase broken"); // [RULE_18]

  property p_tx_lat;
    @(posedge pclk) disable iff (!presetn)
    sync_q && mid_tick |=>
      tx_line_q == {$past(tx_line_q[6:0]), $past(pin0_s)};
  endproperty
  a_tx_lat: assert property (p_tx_lat) else $error("transmit delay line broken"); // [RULE_15]

  property p_rx_lat;
    @(posedge pclk) disable iff (!presetn)
    sync_q && bit_tick |=>
      rx_dat_q == $past(rx_line_q[8]) && rx_line_q[0] == $past(rx_bit);
  endproperty
  a_rx_lat: assert property (p_rx_lat) else $error("receive delay line broken"); // [RULE_16]

endmodule

// ---- sim/rsdp_host.sv ----
`timescale 1ns/1ps
// ****************************************
// Host logic on the raw serial pins
// ****************************************
module rsdp_host (
  input wire logic pclk,
  input wire logic en_sync,
  input wire logic en_async,
  input wire logic bclk,
  input wire logic [15:0] pat,
  input wire logic rxd,
  output logic drv,
  output logic rxf
);
  logic lclk;
  logic bq;
  logic rq;
  int ai;
  int si;
  // Own bit timer, phase unrelated to pclk
  initial begin
    drv = 1'b0;
    bq = 1'b0;
    rq = 1'b0;
    rxf = 1'b0;
    ai = 0;
    si = 0;
    lclk = 1'b0;
    #37;
    forever #400 lclk = ~lclk;
  end
  // Async bits at exactly the programmed period
  always @(posedge lclk) begin
    ai <= en_async ? ai + 1 : 0;
  end
  // Pattern carries the host's own framing; new bit just after bit clock falls
  always @(posedge pclk) begin
    bq <= bclk;
    if (!en_sync) begin
      si <= 0;
    end else if (bq && !bclk) begin
      si <= si + 1;
      drv <= pat[(si + 1) % 16];
    end
    if (en_async) begin
      drv <= pat[ai % 16];
    end else if (!en_sync) begin
      drv <= 1'b0;
    end
  end
  // Host oversamples the data pin, keeps a level only when seen twice
  always @(posedge pclk) begin
    rq <= rxd;
    if (rq == rxd) rxf <= rxd;
  end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  wire pin0_in;
  logic pin0_out, pin0_oe, pin1_out, pin1_oe, pin2_out, pin2_oe;
  logic rx_raw_level, rx_bit, tx_mod_valid, tx_mod_ready;
  logic pkt_bypass, manchester_en, tx_active;
  logic host_drv, en_sync, en_async, p2_q, ta_q, ta_q2, rxf;
  rsdp_pkg::rsdp_txw_t tx_mod_data;
  rsdp_pkg::rsdp_txw_t words[$];
  logic hq[$];
  int fail_count, checks_done;

  // Shared pin 0 level
  assign pin0_in = pin0_oe ? pin0_out : host_drv;

  rsdp_top u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .general_output_pin_0_in(pin0_in), .general_output_pin_0_out(pin0_out),
    .general_output_pin_0_oe(pin0_oe), .general_output_pin_1_out(pin1_out),
    .general_output_pin_1_oe(pin1_oe), .general_output_pin_2_out(pin2_out),
    .general_output_pin_2_oe(pin2_oe), .rx_raw_level(rx_raw_level),
    .rx_bit(rx_bit), .tx_mod_valid(tx_mod_valid), .tx_mod_ready(tx_mod_ready),
    .tx_mod_data(tx_mod_data), .pkt_bypass(pkt_bypass),
    .manchester_en(manchester_en), .tx_active(tx_active)
  );

  rsdp_host u_host (
    .pclk(pclk), .en_sync(en_sync), .en_async(en_async), .bclk(pin2_out),
    .pat(16'hA5D2), .rxd(pin1_out), .drv(host_drv), .rxf(rxf)
  );

  // ****************************************
  // Clock, modulator sink, host bit sampling
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    p2_q <= pin2_out;
    ta_q <= tx_active;
    ta_q2 <= ta_q;
    if (tx_mod_valid === 1'b1 && tx_mod_ready === 1'b1) words.push_back(tx_mod_data);
    if (pin2_out === 1'b1 && p2_q === 1'b0 && ta_q2 === 1'b1) hq.push_back(pin0_in);
  end

  // ****************************************
  // Common tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tout;
    fail_count++;
    $display("ERROR %0t wait limit", $time);
    end_sim();
  endtask
  // APB transfer, entered and left just after a rising edge; answer taken at ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tout();
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(32'(e), 32'h0, "write error");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & mk, x, "read data");
    chk(32'(e), 32'h0, "read error");
  endtask
  // Waits for the bit clock pin to reach a level; counts cycles, samples data pin
  task automatic wclk(input logic lvl, output int n, output logic dv);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pin2_out !== lvl && n < 100);
    if (n >= 100) tout();
    dv = pin1_out;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] f, input logic [1:0] s0,
                                      input logic [1:0] s1, input logic [1:0] s2);
    rsdp_pkg::rsdp_ctrl_t c;
    c = rsdp_pkg::CTRL_RST;
    c.fmt = f;
    c.pin0_sel = s0;
    c.pin1_sel = s1;
    c.pin2_sel = s2;
    c.length_mode = (f == rsdp_pkg::FMT_SYNC) ? 2'h2 : 2'h0;
    return {18'h0, c};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_regs;
    logic [31:0] r;
    logic e;
    chk(32'(manchester_en), 32'h1, "reset coding");
    chk(32'(pkt_bypass), 32'h0, "reset bypass");
    rd(rsdp_pkg::ADDR_STAT, 32'hFFFFFFFF, 32'h0);
    rd(rsdp_pkg::ADDR_CTRL, 32'hFFFFFFFF, {18'h0, rsdp_pkg::CTRL_RST});
    wr(rsdp_pkg::ADDR_RATE, 32'hFFFFFFFF);
    rd(rsdp_pkg::ADDR_RATE, 32'hFFFFFFFF, 32'h0000FFFF);
    wr(rsdp_pkg::ADDR_RATE, {16'h0, rsdp_pkg::RATE_RST});
    rd(rsdp_pkg::ADDR_CMD, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk(r, 32'h0, "unmapped data");
    chk(32'(e), 32'h1, "unmapped error");
  endtask
  task automatic s_async;
    wr(rsdp_pkg::ADDR_CTRL, ctl(rsdp_pkg::FMT_ASYNC, rsdp_pkg::SEL_DATA,
       rsdp_pkg::SEL_DATA, rsdp_pkg::SEL_HIZ));
    repeat (3) @(posedge pclk);
    rd(rsdp_pkg::ADDR_STAT, 32'h0E, 32'h0A);
    chk(32'(manchester_en), 32'h0, "coding in async");
    chk(32'(pkt_bypass), 32'h1, "bypass in async");
    rx_raw_level <= 1'b1;
    @(posedge pclk);
    rx_raw_level <= 1'b0;
    @(negedge pclk);
    chk(32'({pin0_out, pin0_oe, pin1_out, pin1_oe, pin2_oe}), 32'h1E, "raw pulse");
    @(posedge pclk);
    @(negedge pclk);
    chk(32'(pin1_out), 32'h0, "raw pulse end");
    chk(32'(rxf), 32'h0, "glitch filtered");
    @(posedge pclk);
    rx_raw_level <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(rxf), 32'h1, "host level");
    rx_raw_level <= 1'b0;
    en_async <= 1'b1;
    wr(rsdp_pkg::ADDR_CMD, 32'h1);
    words.delete();
    repeat (160) @(posedge pclk);
    chk(32'(words.size() >= 159 && words.size() <= 161), 32'h1, "async samples");
    chk(32'(words[0].sync_bit), 32'h0, "async word kind");
    chk({tx_active, pin0_oe}, 32'h2, "pin 0 input");
  endtask
  task automatic s_buf;
    tx_mod_ready <= 1'b0;
    repeat (12) @(posedge pclk);
    rd(rsdp_pkg::ADDR_STAT, 32'h30, 32'h30);
    wr(rsdp_pkg::ADDR_CMD, 32'h2);
    en_async <= 1'b0;
    wr(rsdp_pkg::ADDR_STAT, 32'h20);
    rd(rsdp_pkg::ADDR_STAT, 32'h21, 32'h0);
    chk(32'(pin0_oe), 32'h1, "pin 0 driven again");
    words.delete();
    tx_mod_ready <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'(words.size()), 32'h2, "drained words");
    rd(rsdp_pkg::ADDR_STAT, 32'h10, 32'h0);
  endtask
  task automatic s_sync;
    int n;
    int bad;
    logic dv;
    logic [15:0] v;
    wr(rsdp_pkg::ADDR_RATE, 32'h1);
    wr(rsdp_pkg::ADDR_CTRL, ctl(rsdp_pkg::FMT_SYNC, rsdp_pkg::SEL_LOW,
       rsdp_pkg::SEL_DATA, rsdp_pkg::SEL_CLK));
    repeat (3) @(posedge pclk);
    rd(rsdp_pkg::ADDR_STAT, 32'h0E, 32'h0C);
    chk(32'(manchester_en), 32'h1, "coding in sync");
    wclk(1'b0, n, dv);
    wclk(1'b1, n, dv);
    wclk(1'b0, n, dv);
    chk(n, rsdp_pkg::OSR, "clock high");
    wclk(1'b1, n, dv);
    chk(n, rsdp_pkg::OSR, "clock low");
    v = 16'h0;
    wclk(1'b0, n, dv);
    rx_bit <= 1'b1;
    wclk(1'b1, n, v[1]);
    wclk(1'b0, n, dv);
    rx_bit <= 1'b0;
    for (int k = 2; k < 15; k++) begin
      wclk(1'b1, n, v[k]);
      wclk(1'b0, n, dv);
    end
    chk(v, 32'h1 << (rsdp_pkg::RX_LAT + 2), "rx delay");
    en_sync <= 1'b1;
    wr(rsdp_pkg::ADDR_CMD, 32'h1);
    words.delete();
    hq.delete();
    for (int k = 0; k < 26; k++) begin
      wclk(1'b1, n, dv);
      wclk(1'b0, n, dv);
    end
    chk(32'(pin0_oe), 32'h0, "sync pin 0 input");
    wr(rsdp_pkg::ADDR_CMD, 32'h2);
    en_sync <= 1'b0;
    bad = 0;
    for (int k = 0; k < words.size(); k++) begin
      if (words[k].sync_bit !== 1'b1) bad++;
      if (k < rsdp_pkg::TX_LAT && words[k].data !== 1'b0) bad++;
      if (k >= rsdp_pkg::TX_LAT && k - rsdp_pkg::TX_LAT < hq.size()) begin
        if (words[k].data !== hq[k - rsdp_pkg::TX_LAT]) bad++;
      end
    end
    chk(32'(words.size() > 16), 32'h1, "sync words");
    chk(bad, 32'h0, "tx delay");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    fail_count = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_raw_level = 1'b0;
    rx_bit = 1'b0;
    tx_mod_ready = 1'b1;
    en_sync = 1'b0;
    en_async = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_async();
    s_buf();
    s_sync();
    end_sim();
  end
endmodule
